// File: common/wcx_pkg.sv
`default_nettype none

package wcx_pkg;

   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_INSTR    = 8'h04;
   localparam logic [7:0] OFS_WREG     = 8'h08;
   localparam logic [7:0] OFS_BANKSEL  = 8'h0C;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_WDCOUNT  = 8'h14;
   localparam logic [7:0] OFS_WDPOST   = 8'h18;
   localparam logic [7:0] OFS_INDEX    = 8'h1C;
   localparam logic [7:0] OFS_MEMADDR  = 8'h20;
   localparam logic [7:0] OFS_MEMDATA  = 8'h24;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTRL_EXT_BIT   = 0;  // Extended instruction set enable.
   localparam int CTRL_SLEEP_BIT = 1;  // Write 1: clears the power-down flag.
   localparam int CTRL_WDEN_BIT  = 2;  // Watchdog counting enable.
   localparam int ST_Z_BIT       = 0;
   localparam int ST_N_BIT       = 1;
   localparam int ST_PD_BIT      = 2;
   localparam int ST_TO_BIT      = 3;
   localparam int OP_D_BIT       = 9;
   localparam int OP_A_BIT       = 8;

   // -----------------------------------------------------------------
   // Opcodes, addressing constants, reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] OPC_CLEAR_WATCHDOG = 16'h0004;
   localparam logic [5:0]  OPC_COMPLEMENT_HI  = 6'h07;    // Upper bits 0001 11.
   localparam logic [7:0]  LIT_OFFSET_MAX     = 8'h5F;
   localparam logic [7:0]  ACCESS_SPLIT       = 8'h80;
   localparam logic [3:0]  ACCESS_HIGH_BANK   = 4'hF;
   localparam logic [3:0]  ACCESS_LOW_BANK    = 4'h0;
   localparam logic [2:0]  CTRL_RESET         = 3'h4;
   localparam logic [7:0]  WDT_CLEAR_VALUE    = 8'h00;

   // -----------------------------------------------------------------
   // Execution sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      WCX_IDLE = 2'b00,
      WCX_EXEC = 2'b01
   } wcx_state_t;

endpackage

`default_nettype wire

// File: design/wcx_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// Watchdog counter with postscaler
// ---------------------------------------------------------------------
module wcx_watchdog #(
   parameter int CNT_W = 8,
   parameter int PS_W  = 7
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // Control
   input  wire logic             run,
   input  wire logic             clear,
   // State
   output logic      [CNT_W-1:0] count_q,
   output logic      [PS_W-1:0]  post_q,
   output logic                  timeout_q
);

   logic ps_wrap;
   logic cnt_wrap;

   // The counter advances once each time the postscaler wraps.
   assign ps_wrap  = &post_q;
   assign cnt_wrap = ps_wrap & (&count_q);

   // Clear dominates counting so a clear never loses to a tick.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q   <= '0;
         post_q    <= '0;
         timeout_q <= 1'b0;
      end else if (ce) begin
         timeout_q <= 1'b0;
         if (clear) begin
            count_q <= '0;
            post_q  <= '0;
         end else if (run) begin
            post_q <= post_q + 1'b1;
            if (ps_wrap) begin
               count_q <= count_q + 1'b1;
            end
            timeout_q <= cnt_wrap;
         end
      end
   end

endmodule

`default_nettype wire

// File: design/wcx_exec.sv
// How it works
// - Opcode 0004h is the clear-watchdog operation.
// - Clear-watchdog zeroes watchdog counter and postscaler.
// - Clear-watchdog sets timeout and power-down flags.
// - Upper bits 000111 complement the addressed byte.
// - Destination bit 0 to working register, 1 back.
// - Access bit 0 access bank, 1 bank-select.
// - Extended set, access 0, f<=5Fh: literal offset.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module wcx_exec #(
   parameter int DATA_AW = 12,
   parameter int WDT_W   = 8,
   parameter int WDPS_W  = 7
) (
   // Clock, reset and clock enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [7:0]          mem [0:(1<<DATA_AW)-1];
   logic [2:0]          ctrl_q;
   logic [15:0]         instr_q;
   logic [7:0]          wreg_q;
   logic [3:0]          bank_select_register_q;
   logic                zero_q;
   logic                neg_q;
   logic                powerdown_flag_n_q;
   logic                timeout_flag_n_q;
   logic [DATA_AW-1:0]  index_q;
   logic [DATA_AW-1:0]  memaddr_q;
   logic [31:0]         prdata_q;
   logic                pready_q;
   logic                pslverr_q;
   wcx_pkg::wcx_state_t state_q;
   wcx_pkg::wcx_state_t state_d;
   logic [WDT_W-1:0]    watchdog_counter;
   logic [WDPS_W-1:0]   wd_post;
   logic                wd_timeout;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   logic        acc_done;
   logic        wr_en;
   logic        hit_ctrl;
   logic        hit_instr;
   logic        hit_wreg;
   logic        hit_bsr;
   logic        hit_status;
   logic        hit_wdc;
   logic        hit_wdp;
   logic        hit_index;
   logic        hit_maddr;
   logic        hit_mdata;
   logic        hit_any;
   logic [31:0] rd_mux;

   // The slave answers in the second access-phase cycle, one wait state.
   assign acc_done   = psel & penable & pready_q;
   assign wr_en      = acc_done & pwrite & hit_any;
   assign hit_ctrl   = (paddr == wcx_pkg::OFS_CTRL);
   assign hit_instr  = (paddr == wcx_pkg::OFS_INSTR);
   assign hit_wreg   = (paddr == wcx_pkg::OFS_WREG);
   assign hit_bsr    = (paddr == wcx_pkg::OFS_BANKSEL);
   assign hit_status = (paddr == wcx_pkg::OFS_STATUS);
   assign hit_wdc    = (paddr == wcx_pkg::OFS_WDCOUNT);
   assign hit_wdp    = (paddr == wcx_pkg::OFS_WDPOST);
   assign hit_index  = (paddr == wcx_pkg::OFS_INDEX);
   assign hit_maddr  = (paddr == wcx_pkg::OFS_MEMADDR);
   assign hit_mdata  = (paddr == wcx_pkg::OFS_MEMDATA);
   assign hit_any    = hit_ctrl | hit_instr | hit_wreg | hit_bsr | hit_status
                     | hit_wdc | hit_wdp | hit_index | hit_maddr | hit_mdata;

   // Read data selection; unmapped addresses read as zero.
   logic [7:0] status_byte;
   assign status_byte = {4'h0, timeout_flag_n_q, powerdown_flag_n_q, neg_q, zero_q};
   assign rd_mux = hit_ctrl   ? {29'h0, ctrl_q}                                 :
                   hit_instr  ? {16'h0, instr_q}                                :
                   hit_wreg   ? {24'h0, wreg_q}                                 :
                   hit_bsr    ? {28'h0, bank_select_register_q}                 :
                   hit_status ? {24'h0, status_byte}                            :
                   hit_wdc    ? {{(32-WDT_W){1'b0}}, watchdog_counter}          :
                   hit_wdp    ? {{(32-WDPS_W){1'b0}}, wd_post}                  :
                   hit_index  ? {{(32-DATA_AW){1'b0}}, index_q}                 :
                   hit_maddr  ? {{(32-DATA_AW){1'b0}}, memaddr_q}               :
                   hit_mdata  ? {24'h0, mem[memaddr_q]}                         :
                                32'h0000_0000;

   // -----------------------------------------------------------------
   // Instruction decode and operand addressing
   // -----------------------------------------------------------------
   logic               is_clear_watchdog_op;
   logic               is_comp;
   logic               dest_file;
   logic               acc_bank;
   logic [7:0]         ffield;
   logic               lit_off;
   logic [DATA_AW-1:0] eff_addr;
   logic [DATA_AW-1:0] bank_addr;
   logic [DATA_AW-1:0] access_addr;
   logic [7:0]         result;
   logic               executing;
   logic               do_clear_watchdog_op;
   logic               do_comp;

   assign is_clear_watchdog_op = (instr_q == wcx_pkg::OPC_CLEAR_WATCHDOG);
   assign is_comp   = (instr_q[15:10] == wcx_pkg::OPC_COMPLEMENT_HI);
   assign dest_file = instr_q[wcx_pkg::OP_D_BIT];
   assign acc_bank  = ~instr_q[wcx_pkg::OP_A_BIT];
   assign ffield    = instr_q[7:0];

   // Literal offset applies only in the lower part of the access bank.
   assign lit_off     = ctrl_q[wcx_pkg::CTRL_EXT_BIT] & acc_bank
                      & (ffield <= wcx_pkg::LIT_OFFSET_MAX);
   assign bank_addr   = DATA_AW'({bank_select_register_q, ffield});
   assign access_addr = (ffield < wcx_pkg::ACCESS_SPLIT)
                      ? DATA_AW'({wcx_pkg::ACCESS_LOW_BANK, ffield})
                      : DATA_AW'({wcx_pkg::ACCESS_HIGH_BANK, ffield});
   assign eff_addr    = lit_off  ? DATA_AW'(index_q + DATA_AW'(ffield)) :
                        acc_bank ? access_addr : bank_addr;
   assign result      = ~mem[eff_addr];

   assign executing = (state_q == wcx_pkg::WCX_EXEC);
   assign do_clear_watchdog_op = executing & is_clear_watchdog_op;
   assign do_comp   = executing & is_comp;

   // A written opcode is executed in the single cycle that follows.
   always_comb begin
      state_d = state_q;
      case (state_q)
         wcx_pkg::WCX_IDLE: begin
            if (wr_en && hit_instr) begin
               state_d = wcx_pkg::WCX_EXEC;
            end
         end
         wcx_pkg::WCX_EXEC: begin
            state_d = wcx_pkg::WCX_IDLE;
         end
         default: begin
            state_d = wcx_pkg::WCX_IDLE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Watchdog
   // -----------------------------------------------------------------
   wcx_watchdog #(
      .CNT_W (WDT_W),
      .PS_W  (WDPS_W)
   ) u_watchdog (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .run       (ctrl_q[wcx_pkg::CTRL_WDEN_BIT]),
      .clear     (do_clear_watchdog_op),
      .count_q   (watchdog_counter),
      .post_q    (wd_post),
      .timeout_q (wd_timeout)
   );

   // -----------------------------------------------------------------
   // Bus response flops
   // -----------------------------------------------------------------
   // Registered pready costs one wait state but keeps every output on a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (ce) begin
         pready_q  <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~hit_any;
         if (psel && penable && !pready_q && !pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // -----------------------------------------------------------------
   // Software registers and sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q                <= wcx_pkg::WCX_IDLE;
         ctrl_q                 <= wcx_pkg::CTRL_RESET;
         instr_q                <= 16'h0000;
         bank_select_register_q <= 4'h0;
         index_q                <= '0;
         memaddr_q              <= '0;
      end else if (ce) begin
         state_q <= state_d;
         ctrl_q[wcx_pkg::CTRL_SLEEP_BIT] <= 1'b0;  // Sleep bit is a strobe.
         if (wr_en && hit_ctrl) begin
            ctrl_q <= pwdata[2:0];
         end
         if (wr_en && hit_instr) begin
            instr_q <= pwdata[15:0];
         end
         if (wr_en && hit_bsr) begin
            bank_select_register_q <= pwdata[3:0];
         end
         if (wr_en && hit_index) begin
            index_q <= pwdata[DATA_AW-1:0];
         end
         if (wr_en && hit_maddr) begin
            memaddr_q <= pwdata[DATA_AW-1:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Working register and status flags
   // -----------------------------------------------------------------
   // Clear-watchdog wins over a timeout or sleep in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wreg_q             <= 8'h00;
         zero_q             <= 1'b0;
         neg_q              <= 1'b0;
         powerdown_flag_n_q <= 1'b1;
         timeout_flag_n_q   <= 1'b1;
      end else if (ce) begin
         if (wd_timeout) begin
            timeout_flag_n_q <= 1'b0;
         end
         if (ctrl_q[wcx_pkg::CTRL_SLEEP_BIT]) begin
            powerdown_flag_n_q <= 1'b0;
         end
         if (do_clear_watchdog_op) begin
            timeout_flag_n_q   <= 1'b1;
            powerdown_flag_n_q <= 1'b1;
         end
         if (do_comp) begin
            neg_q  <= result[7];
            zero_q <= (result == 8'h00);
            if (!dest_file) begin
               wreg_q <= result;
            end
         end else if (wr_en && hit_wreg) begin
            wreg_q <= pwdata[7:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Data memory
   // -----------------------------------------------------------------
   // No reset: the array models plain data RAM.
   always_ff @(posedge pclk) begin
      if (ce) begin
         if (do_comp && dest_file) begin
            mem[eff_addr] <= result;
         end else if (wr_en && hit_mdata) begin
            mem[memaddr_q] <= pwdata[7:0];
         end
      end
   end

endmodule

`default_nettype wire

// File: tb/wcx_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Port checker for the execution block
// ---------------------------------------------------------------
module wcx_exec_chk (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   logic done;
   logic unmapped;

   // A completed transfer, and whether its address decodes to no register.
   assign done     = psel && penable && pready;
   assign unmapped = (paddr > wcx_pkg::OFS_MEMDATA) || (paddr[1:0] != 2'h0);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_clear;
      done && pwrite && paddr == wcx_pkg::OFS_INSTR
         && pwdata[15:0] == wcx_pkg::OPC_CLEAR_WATCHDOG;
   endsequence
   sequence s_read(logic [7:0] a);
      done && !pwrite && paddr == a;
   endsequence

   // The clock enable stays high in the bench, so the wait state is fixed.
   a_ready_phase: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   a_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("access phase not two cycles");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_unmapped: assert property (done && unmapped |-> pslverr)
      else $error("unmapped access without error");
   a_err_mapped: assert property (done && !unmapped |-> !pslverr)
      else $error("mapped access with error");
   a_rd_unmapped: assert property (done && !pwrite && unmapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_upper: assert property (s_read(wcx_pkg::OFS_STATUS) |-> prdata[31:4] == 28'h0)
      else $error("status upper bits not zero");
   a_clear_flags: assert property (
      s_clear ##[3:5] s_read(wcx_pkg::OFS_STATUS) |-> prdata[3:2] == 2'h3)
      else $error("flags not set after watchdog clear");
   a_clear_count: assert property (
      s_clear ##[3:12] s_read(wcx_pkg::OFS_WDCOUNT) |-> prdata == 32'h0)
      else $error("watchdog count not zero after clear");
endmodule

bind wcx_exec wcx_exec_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct {string nm; logic rd; logic [32:0] ex;} wcx_note_t;
   logic        pclk;
   logic        presetn;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   wcx_note_t   notes[$];
   wcx_note_t   nt;
   int          errors;
   int          comparisons;
   int          seed;
   int          i;
   logic [3:0]  st;
   logic [7:0]  w;
   logic [31:0] rv;

   wcx_exec DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // Free-running 100 MHz clock.
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------
   task automatic mism(input string nm, input logic [31:0] e, input logic [31:0] s);
      $display("mismatch %s expected %h seen %h", nm, e, s);
      errors++;
   endtask

   task automatic summarize();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic unm(input logic [7:0] a);
      return (a > wcx_pkg::OFS_MEMDATA) || (a[1:0] != 2'h0);
   endfunction

   // ---------------------------------------------------------------
   // APB master; every transfer leaves a note for the watcher.
   // ---------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input string nm);
      int n;
      n = 0;
      notes.push_back('{nm, !wr, {unm(a), ex}});
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'h0;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) mism("pready", 32'h1, 32'h0);
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'h1, a, d, 32'h0, "write");
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
      xfer(1'h0, a, 32'h0, ex, nm);
   endtask

   // Complement a seeded byte at ea and read back every place it may land.
   task automatic comp(input logic d, input logic a, input logic [7:0] f,
                       input logic [11:0] ea, input logic [7:0] v);
      logic [7:0] r;
      r = ~v;
      wr(wcx_pkg::OFS_MEMADDR, {20'h0, ea});
      wr(wcx_pkg::OFS_MEMDATA, {24'h0, v});
      wr(wcx_pkg::OFS_INSTR, {16'h0, wcx_pkg::OPC_COMPLEMENT_HI, d, a, f});
      if (!d) w = r;
      st[1:0] = {r[7], r == 8'h00};
      rd(wcx_pkg::OFS_MEMDATA, {24'h0, d ? r : v}, "mem");
      rd(wcx_pkg::OFS_WREG, {24'h0, w}, "wreg");
      rd(wcx_pkg::OFS_STATUS, {28'h0, st}, "status");
   endtask

   // Watcher: the oldest note belongs to the transfer completing now.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'h1) begin
         if (notes.size() == 0) mism("note", 32'h0, 32'h1);
         else begin
            nt = notes.pop_front();
            comparisons++;
            if (pslverr !== nt.ex[32]) mism({nt.nm, "_err"}, nt.ex[32], pslverr);
            if (nt.rd && prdata !== nt.ex[31:0]) mism(nt.nm, nt.ex[31:0], prdata);
         end
      end
   end

   // Run limit well above the few hundred cycles the sequence needs; a hang ends here.
   initial begin
      repeat (5000) @(posedge pclk);
      mism("run", 32'h0, 32'h1);
      summarize();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 7199;
      errors = 0;
      comparisons = 0;
      st = 4'hC;
      w = 8'h00;
      presetn = 1'h0;
      ce = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rd(wcx_pkg::OFS_CTRL, 32'h4, "ctrl");
      rd(wcx_pkg::OFS_STATUS, 32'hC, "status");
      rd(wcx_pkg::OFS_BANKSEL, 32'h0, "bsr");
      rd(8'h28, 32'h0, "unmapped");
      wr(8'h06, 32'hFFFF);
      wr(wcx_pkg::OFS_STATUS, 32'h0);
      rd(wcx_pkg::OFS_STATUS, 32'hC, "status");
      // Bank-select addressing with both destinations.
      for (i = 0; i < 4; i++) begin
         rv = $random(seed);
         wr(wcx_pkg::OFS_BANKSEL, {28'h0, rv[11:8]});
         comp(i[0], 1'h1, rv[7:0], rv[11:0], rv[23:16]);
      end
      // Access bank on either side of the split; the second result is zero.
      comp(1'h0, 1'h0, 8'h7F, 12'h07F, rv[31:24]);
      comp(1'h1, 1'h0, 8'h80, 12'hF80, 8'hFF);
      // Literal offset applies up to 5Fh only while the extended set is on.
      rv = $random(seed);
      wr(wcx_pkg::OFS_CTRL, 32'h5);
      wr(wcx_pkg::OFS_INDEX, {20'h0, rv[11:0]});
      comp(1'h1, 1'h0, 8'h5F, rv[11:0] + 12'h05F, rv[23:16]);
      comp(1'h0, 1'h0, 8'h60, 12'h060, rv[31:24]);
      // Stopping the watchdog makes its cleared state stay readable.
      repeat (200) @(posedge pclk);
      wr(wcx_pkg::OFS_CTRL, 32'h2);
      st[2] = 1'h0;
      wr(wcx_pkg::OFS_INSTR, 32'h0005);
      rd(wcx_pkg::OFS_STATUS, {28'h0, st}, "status");
      wr(wcx_pkg::OFS_INSTR, {16'h0, wcx_pkg::OPC_CLEAR_WATCHDOG});
      st[3:2] = 2'h3;
      rd(wcx_pkg::OFS_STATUS, {28'h0, st}, "status");
      rd(wcx_pkg::OFS_WDCOUNT, 32'h0, "wdcount");
      rd(wcx_pkg::OFS_WDPOST, 32'h0, "wdpost");
      summarize();
   end
endmodule

`default_nettype wire
